// ===== hw/atb_prescaler.sv
// Prescaler with buffered divide setting
`timescale 1ns/100ps
`default_nettype none
module atb_prescaler
   import atb_pkg::*;
#(
   parameter int PSC_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic [PSC_W-1:0] setting,
   atb_tick_if.pre tk
);
   // Counter and setting hold at most sixteen bits
   if (PSC_W < 1 || PSC_W > 16) begin : g_bad_width
      $error("PSC_W out of range");
   end

   logic [PSC_W-1:0] active;
   logic [PSC_W-1:0] count;

   // Buffered ratio, loaded only on update
   always_ff @(posedge clock) begin
      if (rst) begin
         active <= PSC_RESET[PSC_W-1:0];
      end else if (tk.load) begin
         active <= setting;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || tk.restart) begin
         count <= '0;
      end else if (run) begin
         count <= (count >= active) ? '0 : count + 1'b1;
      end
   end

   // Core masks ticks under a forced update, keeping this path loop-free
   assign tk.tick = run && (count >= active);
endmodule : atb_prescaler
`default_nettype wire

// ===== hw/atb_time_base.sv
// Time-base unit: counter, reload, repetition and update logic
`timescale 1ns/100ps
`default_nettype none
module atb_time_base
   import atb_pkg::*;
#(
   parameter int PSC_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control bits
   input wire logic counter_enable,
   input wire logic update_disable,
   input wire logic update_request_select,
   input wire logic reload_buffer_enable,
   input wire logic [1:0] align_mode,
   input wire logic dir_down_wr,
   input wire logic dir_wr,
   // Event triggers
   input wire logic update_generate,
   input wire logic slave_update,
   // Register writes
   input wire logic counter_wr,
   input wire logic [15:0] counter_wdata,
   input wire logic reload_wr,
   input wire logic [15:0] reload_wdata,
   input wire logic prescale_wr,
   input wire logic [15:0] prescale_wdata,
   input wire logic repeat_wr,
   input wire logic [7:0] repeat_wdata,
   input wire logic flag_clear,
   // Register reads and status
   output logic [15:0] counter_value_reg,
   output logic [15:0] reload_value_reg,
   output logic [15:0] prescale_setting_reg,
   output logic [7:0] repeat_count_reg,
   output logic [15:0] reload_active,
   output logic [7:0] repeat_remaining,
   output logic dir_down,
   output logic update_flag,
   output logic update_event,
   output logic overflow,
   output logic underflow
);
   // Prescale setting port is sixteen bits wide
   if (PSC_W != 16) begin : g_bad_width
      $error("PSC_W must be 16");
   end

   atb_tick_if tk ();
   logic run;
   logic center;
   logic sw_upd;
   logic ovf;
   logic unf;
   logic wrap;
   logic rep_zero;
   logic hw_upd;
   logic upd;
   logic [15:0] next_cnt;
   logic next_dir;
   logic [15:0] next_reload;

   // ------------------------------------------------------------------
   // Enable registered: first count one cycle after enable is set
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         run <= 1'b0;
      end else begin
         run <= counter_enable;
      end
   end

   atb_prescaler #(.PSC_W(PSC_W)) atb_prescaler_i (
      .clock(clock),
      .rst(rst),
      .run(run),
      .setting(prescale_setting_reg),
      .tk(tk)
   );

   assign center = (align_mode != ATB_EDGE);
   assign sw_upd = update_generate || slave_update;
   // Wrap detection
   always_comb begin
      ovf = 1'b0;
      unf = 1'b0;
      // Forced update wins over a wrap in the same cycle
      if (tk.tick && !sw_upd) begin
         if (center) begin
            ovf = !dir_down && (counter_value_reg >= reload_active - 16'h0001);
            unf = dir_down && (counter_value_reg <= 16'h0001);
         end else if (!dir_down) begin
            ovf = (counter_value_reg >= reload_active);
         end else begin
            unf = (counter_value_reg == 16'h0000);
         end
      end
   end
   assign wrap = ovf || unf;
   assign rep_zero = (repeat_remaining == 8'h00);
   assign hw_upd = wrap && rep_zero && !update_disable;
   assign upd = hw_upd || sw_upd;
   assign tk.restart = sw_upd || (wrap && !center);
   assign tk.load = upd;

   // ------------------------------------------------------------------
   // Preload registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         reload_value_reg <= RELOAD_RESET;
         prescale_setting_reg <= PSC_RESET;
         repeat_count_reg <= REP_RESET;
      end else begin
         if (reload_wr) reload_value_reg <= reload_wdata;
         if (prescale_wr) prescale_setting_reg <= prescale_wdata;
         if (repeat_wr) repeat_count_reg <= repeat_wdata;
      end
   end

   // Active reload: transparent when buffering is off
   always_comb begin
      next_reload = reload_active;
      if (!reload_buffer_enable) begin
         next_reload = reload_wr ? reload_wdata : reload_value_reg;
      end else if (upd) begin
         next_reload = reload_value_reg;
      end
   end

   // Counter restarts read next_reload, so a new period sees the new value
   always_ff @(posedge clock) begin
      if (rst) begin
         reload_active <= RELOAD_RESET;
      end else begin
         reload_active <= next_reload;
      end
   end

   // Repetition down-counter
   always_ff @(posedge clock) begin
      if (rst) begin
         repeat_remaining <= REP_RESET;
      end else if (upd) begin
         repeat_remaining <= repeat_count_reg;
      end else if (wrap && !rep_zero) begin
         repeat_remaining <= repeat_remaining - 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Counter and direction
   // ------------------------------------------------------------------
   always_comb begin
      next_cnt = counter_value_reg;
      next_dir = dir_down;
      if (!center && dir_wr) begin
         next_dir = dir_down_wr;
      end
      if (sw_upd) begin
         // Forced restart: zero, or reload in down mode
         if (!center && dir_down) begin
            next_cnt = next_reload;
         end else begin
            next_cnt = 16'h0000;
         end
         if (center) next_dir = 1'b0;
      end else if (ovf) begin
         if (center) begin
            next_cnt = next_reload;
            next_dir = 1'b1;
         end else begin
            next_cnt = 16'h0000;
         end
      end else if (unf) begin
         if (center) begin
            next_cnt = 16'h0000;
            next_dir = 1'b0;
         end else begin
            // New reload already visible to the next period
            next_cnt = next_reload;
         end
      end else if (tk.tick) begin
         next_cnt = dir_down ? counter_value_reg - 16'h0001
                             : counter_value_reg + 16'h0001;
      end
      if (counter_wr) begin
         next_cnt = counter_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         counter_value_reg <= CNT_RESET;
         dir_down <= 1'b0;
      end else begin
         counter_value_reg <= next_cnt;
         dir_down <= next_dir;
      end
   end

   // ------------------------------------------------------------------
   // Flags and event pulses
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         update_flag <= 1'b0;
      end else if (hw_upd || (sw_upd && !update_request_select)) begin
         update_flag <= 1'b1;
      end else if (flag_clear) begin
         update_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         update_event <= 1'b0;
         overflow <= 1'b0;
         underflow <= 1'b0;
      end else begin
         update_event <= upd;
         overflow <= ovf;
         underflow <= unf;
      end
   end
endmodule : atb_time_base
`default_nettype wire

// ===== shared/atb_pkg.sv
// Constants and types shared by the timer time-base unit
// ----------------------------------------------------------------------------
// What this block does
// - Sixteen-bit counter with reload value, counting up, down or both.
// - Prescaler divides timer clock by any factor 1 to 65536.
// - Prescaler setting is buffered and takes effect at next update event.
// - Reload writes go to preload; copied immediately or at update per buffering.
// - Counter advances only while enabled; counting starts one cycle after enable.
// - Counter, reload and prescaler readable and writable at any time.
// - Up counting goes 0 to reload, wraps to 0 with overflow.
// - Update on every wrap without repetition, else after programmed periods.
// - Software update-generate bit or slave request makes update; bit self-clears.
// - Update disable blocks wrap updates, not forced ones; up mode still restarts counter and prescaler.
// - With request select, software update transfers registers but sets no flag.
// - Update sets flag, reloads repetition, reload and prescaler buffers.
// - Down counting goes reload to 0, restarts at reload with underflow.
// - Down mode with updates disabled restarts at active reload, prescaler zero.
// - Down mode loads new reload before reloading counter at update.
// - Center mode counts 0 to reload-1 overflow, down to 1 underflow.
// - Center mode ignores direction writes; hardware shows current direction.
// - Center mode updates at overflow and underflow; software update restarts zero.
// - Center mode with updates disabled keeps counting with active reload.
// - Center overflow update refreshes reload before reloading counter.
// - Repetition decrements on overflow up, underflow down, both in center.
// - Forced update is immediate, ignores repetition and reloads it.
// ----------------------------------------------------------------------------
package atb_pkg;
   localparam int CNT_W = 16;
   localparam int REP_W = 8;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'hffff;
   localparam logic [15:0] PSC_RESET = 16'h0000;
   localparam logic [7:0] REP_RESET = 8'h00;

   typedef enum logic [1:0] {
      ATB_EDGE = 2'h0,
      ATB_CENTER1 = 2'h1,
      ATB_CENTER2 = 2'h2,
      ATB_CENTER3 = 2'h3
   } atb_align_t;
endpackage : atb_pkg

// ===== shared/atb_tick_if.sv
// Tick interface between prescaler and counter core
`timescale 1ns/100ps
`default_nettype none
interface atb_tick_if;
   logic tick;
   logic restart;
   logic load;
   modport pre (output tick, input restart, input load);
   modport core (input tick, output restart, output load);
endinterface : atb_tick_if
`default_nettype wire

// ===== tb/atb_time_base_bench.sv
// Self-checking bench for the time-base unit
`timescale 1ns/100ps
`default_nettype none
module atb_time_base_bench
   import atb_pkg::*;
;
   logic clock = 0;
   logic rst = 1;
   logic counter_enable = 0, update_disable = 0, update_request_select = 0;
   logic reload_buffer_enable = 0;
   logic [1:0] align_mode = 2'h0;
   logic [7:0] stb = 8'h00;
   logic [15:0] wd = 16'h0000;
   logic [15:0] counter_value_reg, reload_value_reg, prescale_setting_reg, reload_active;
   logic [7:0] repeat_count_reg, repeat_remaining;
   logic dir_down, update_flag, update_event, overflow, underflow;
   int miscompares = 0, checked = 0, no = 0, nu = 0, ne = 0;
   // Strobe index: 0 cnt 1 reload 2 psc 3 rep 4 sw upd 5 slave 6 clear 7 dir
   atb_time_base atb_time_base_i (.clock, .rst, .counter_enable, .update_disable,
      .update_request_select, .reload_buffer_enable, .align_mode, .dir_down_wr(wd[0]),
      .dir_wr(stb[7]), .update_generate(stb[4]), .slave_update(stb[5]), .counter_wr(stb[0]),
      .counter_wdata(wd), .reload_wr(stb[1]), .reload_wdata(wd), .prescale_wr(stb[2]),
      .prescale_wdata(wd), .repeat_wr(stb[3]), .repeat_wdata(wd[7:0]), .flag_clear(stb[6]),
      .counter_value_reg, .reload_value_reg, .prescale_setting_reg, .repeat_count_reg,
      .reload_active, .repeat_remaining, .dir_down, .update_flag, .update_event, .overflow,
      .underflow);
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      no <= no + int'(overflow);
      nu <= nu + int'(underflow);
      ne <= ne + int'(update_event);
   end
   // ----
   // Access tasks
   // ----
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic put(input int k, input logic [15:0] d);
      stb <= 8'h01 << k;
      wd <= d;
      @(posedge clock);
      stb <= 8'h00;
      // Idle edge so the next call never re-drives the strobe at once
      @(posedge clock);
   endtask : put
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   // Counts wraps and updates over n cycles from a wrap
   task automatic span(input int n, input logic [15:0] eo, eu, ev);
      int so, su, se;
      @(posedge clock iff (overflow | underflow));
      so = no;
      su = nu;
      se = ne;
      tick(n);
      chk(16'(no - so), eo);
      chk(16'(nu - su), eu);
      chk(16'(ne - se), ev);
   endtask : span
   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   // ----
   // Tests
   // ----
   initial begin
      tick(6);
      rst <= 1'b0;
      tick(1);
      chk(counter_value_reg, CNT_RESET);
      chk(reload_active, RELOAD_RESET);
      chk(prescale_setting_reg, PSC_RESET);
      $display("reset done");
      put(1, 16'h0003);
      counter_enable <= 1'b1;
      tick(2);
      chk(reload_active, 16'h0003);
      chk(counter_value_reg, 16'h0000);
      tick(1);
      chk(counter_value_reg, 16'h0001);
      span(40, 10, 0, 10);
      put(2, 16'h0001);
      chk(prescale_setting_reg, 16'h0001);
      put(4, 16'h0000);
      span(40, 5, 0, 5);
      put(3, 16'h0002);
      chk(16'(repeat_count_reg), 16'h0002);
      put(4, 16'h0000);
      span(48, 6, 0, 2);
      $display("up count done");
      update_disable <= 1'b1;
      span(48, 6, 0, 0);
      update_request_select <= 1'b1;
      reload_buffer_enable <= 1'b1;
      put(6, 16'h0000);
      put(1, 16'h0005);
      tick(2);
      chk(reload_active, 16'h0003);
      chk(reload_value_reg, 16'h0005);
      put(4, 16'h0000);
      tick(1);
      chk(16'(update_flag), 16'h0000);
      chk(reload_active, 16'h0005);
      chk(16'(repeat_remaining), 16'h0002);
      update_request_select <= 1'b0;
      put(5, 16'h0000);
      tick(1);
      chk(16'(update_flag), 16'h0001);
      update_disable <= 1'b0;
      $display("update control done");
      put(3, 16'h0000);
      put(7, 16'h0001);
      put(4, 16'h0000);
      span(48, 0, 4, 4);
      put(1, 16'h0002);
      span(24, 0, 4, 4);
      update_disable <= 1'b1;
      put(1, 16'h0003);
      span(24, 0, 4, 0);
      update_disable <= 1'b0;
      $display("down count done");
      align_mode <= 2'h1;
      put(1, 16'h0005);
      put(4, 16'h0000);
      put(7, 16'h0001);
      tick(1);
      chk(16'(dir_down), 16'h0000);
      span(40, 2, 2, 4);
      update_disable <= 1'b1;
      span(40, 2, 2, 0);
      counter_enable <= 1'b0;
      put(0, 16'h0004);
      tick(3);
      chk(counter_value_reg, 16'h0004);
      $display("center count done");
      tally_and_finish();
   end
   initial begin
      tick(3000);
      miscompares++;
      tally_and_finish();
   end
endmodule : atb_time_base_bench
`default_nettype wire

// ===== tb/atb_time_base_monitor.sv
// Port assertions for the time-base unit
`timescale 1ns/100ps
`default_nettype none
module atb_time_base_monitor
   import atb_pkg::*;
#(
   parameter int PSC_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Controls
   input wire logic counter_enable,
   input wire logic update_disable,
   input wire logic [1:0] align_mode,
   input wire logic update_generate,
   input wire logic slave_update,
   input wire logic counter_wr,
   input wire logic repeat_wr,
   // Status
   input wire logic [15:0] counter_value_reg,
   input wire logic [15:0] reload_active,
   input wire logic [7:0] repeat_count_reg,
   input wire logic [7:0] repeat_remaining,
   input wire logic dir_down,
   input wire logic update_flag,
   input wire logic update_event,
   input wire logic overflow,
   input wire logic underflow
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence sw_s;
      (update_generate || slave_update) && !counter_wr;
   endsequence
   sequence calm_s;
      !$past(counter_wr) && $stable(align_mode);
   endsequence
   forced_upd_a: assert property (sw_s |-> ##[1:2] update_event)
      else $error("no update after forced request");
   forced_rep_a: assert property (sw_s ##0 !repeat_wr |=>
      repeat_remaining == repeat_count_reg) else $error("repeat not reloaded");
   sw_restart_a: assert property (sw_s ##0 !dir_down |=>
      counter_value_reg == 16'h0000) else $error("no restart on forced update");
   idle_hold_a: assert property ((!counter_enable && !counter_wr && !update_generate
      && !slave_update) [*2] |=> $stable(counter_value_reg)) else $error("counted while off");
   up_wrap_a: assert property ((overflow && align_mode == 2'h0 && !dir_down) ##0 calm_s
      |-> counter_value_reg == 16'h0000) else $error("up wrap not to zero");
   down_wrap_a: assert property ((underflow && align_mode == 2'h0 && dir_down) ##0 calm_s
      |-> counter_value_reg == reload_active) else $error("down wrap not to reload");
   center_top_a: assert property ((overflow && align_mode != 2'h0) ##0 calm_s
      |-> dir_down && counter_value_reg == reload_active) else $error("bad center top");
   center_low_a: assert property ((underflow && align_mode != 2'h0) ##0 calm_s
      |-> !dir_down && counter_value_reg == 16'h0000) else $error("bad center bottom");
   disabled_upd_a: assert property ((overflow || underflow) && update_disable
      && $past(update_disable) && !$past(update_generate || slave_update)
      && !$past(update_generate || slave_update, 2) |-> !update_event)
      else $error("update while disabled");
   flag_cause_a: assert property ($rose(update_flag) |-> update_event)
      else $error("flag without update");
endmodule : atb_time_base_monitor
bind atb_time_base atb_time_base_monitor #(.PSC_W(PSC_W)) atb_time_base_monitor_i (
   .clock, .rst, .counter_enable, .update_disable, .align_mode, .update_generate,
   .slave_update, .counter_wr, .repeat_wr, .counter_value_reg, .reload_active,
   .repeat_count_reg, .repeat_remaining, .dir_down, .update_flag, .update_event,
   .overflow, .underflow);
`default_nettype wire
